// File: rtcs_map.svh
// Register addresses, field positions and reset values of the real-time clock timer.
// Assumes it is included by bare name from the package and the testbench.
`ifndef RTCS_MAP_SVH
`define RTCS_MAP_SVH
`define RTCS_ADDR_CLK_CTL_FOUR 8'h42
`define RTCS_ADDR_SYS_FLAG_IE 8'h8E
`define RTCS_ADDR_PWR_CTL_ONE 8'h97
`define RTCS_ADDR_TIMER_VALUE 8'hB6
`define RTCS_ADDR_CLK_CONTROL 8'hBE
`define RTCS_BIT_ENABLE 7
`define RTCS_BIT_OUT_EN 6
`define RTCS_BIT_FLAG 4
`define RTCS_BIT_IRQ_EN 4
`define RTCS_RELOAD_RST 6'h3F
`define RTCS_COUNT_RST 6'h3F
`define RTCS_COUNT_MAX 6'h3F
`define RTCS_TAP_LO_RST 2'h1
`define RTCS_TAP_HI_RST 2'h0
`define RTCS_TAP_DIRECT 4'hF
`define RTCS_PSC_FULL 15'h7FFF
`define RTCS_PSC_ONE 15'h0001
`define RTCS_COUNT_ONE 6'h01
`define RTCS_READ_ZERO 8'h00
`define RTCS_SYS_PERIOD_EXP 21
`endif

// File: rtcs_pkg.sv
// Types shared by the real-time clock timer.
// Assumes rtcs_map.svh is on the include path.
`include "rtcs_map.svh"
package rtcs_pkg;
   typedef enum logic [2:0]
   {
      RTCS_SRC_EXT_PIN = 3'b000,
      RTCS_SRC_SLOW_OSC = 3'b001,
      RTCS_SRC_WDT_PSC = 3'b010,
      RTCS_SRC_WDT_OVF = 3'b011,
      RTCS_SRC_SYSCLK = 3'b100
   } rtcs_src_t;

   typedef struct packed
   {
      logic enable;
      logic out_en;
      logic [5:0] reload;
      logic [3:0] tap;
      logic [5:0] count;
      logic [2:0] src;
      logic [2:0] psc_ctl;
      logic irq_en;
      logic flag;
      logic [14:0] psc;
      logic toggle;
      logic [1:0] ext_sync;
      logic [1:0] slow_sync;
      logic ext_prev;
      logic slow_prev;
      logic wps_prev;
      logic [7:0] rdata;
   } rtcs_state_t;
endpackage : rtcs_pkg

// File: rtcs_timer.sv
// Real-time clock and system timer: selectable source, 15-stage prescaler, 6-bit counter.
// Assumes an SFR port from the CPU on clk and a reset input that is power-on reset only.
module rtcs_timer
   import rtcs_pkg::*;
(
   // Clock and power-on reset
   input wire logic clk,
   input wire logic reset,
   // SFR access port
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_page_p,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   // Prescaler sources
   input wire logic external_clock_input,
   input wire logic internal_slow_oscillator,
   input wire logic watchdog_prescaler_out,
   input wire logic watchdog_overflow_out,
   // Overflow output pin
   output logic overflow_toggle_pin,
   output logic overflow_toggle_oe,
   // Status towards the interrupt and power controller
   output logic overflow_flag,
   output logic system_flag_irq,
   output logic wake_request
);

   localparam rtcs_state_t RST_STATE = '{
      enable: 1'b0,
      out_en: 1'b0,
      reload: `RTCS_RELOAD_RST,
      tap: {`RTCS_TAP_HI_RST, `RTCS_TAP_LO_RST},
      count: `RTCS_COUNT_RST,
      src: RTCS_SRC_EXT_PIN,
      psc_ctl: 3'h0,
      irq_en: 1'b0,
      flag: 1'b0,
      psc: 15'h0000,
      toggle: 1'b0,
      ext_sync: 2'h0,
      slow_sync: 2'h0,
      ext_prev: 1'b0,
      slow_prev: 1'b0,
      wps_prev: 1'b0,
      rdata: `RTCS_READ_ZERO
   };

   rtcs_state_t s;
   rtcs_state_t next_s;
   logic src_tick;
   logic tap_tick;
   logic wrap;
   logic wr_ctl;
   logic wr_tmr;
   logic wr_ck4;
   logic wr_pw1;
   logic wr_system_flag_irq_enable;

   // Prescaler bits that must all be ones for a carry out of the tapped stage.
   function automatic logic [14:0] tap_mask(input logic [3:0] code);
      tap_mask = `RTCS_PSC_FULL >> code;
   endfunction : tap_mask

   function automatic logic sfr_hit(input logic [7:0] addr, input logic [7:0] reg_addr);
      sfr_hit = (addr == reg_addr);
   endfunction : sfr_hit

   always_comb
   begin
      next_s = s;
      wr_ctl = sfr_wr && sfr_hit(sfr_addr, `RTCS_ADDR_CLK_CONTROL);
      // The timer register lives in the normal pages only and is locked while running.
      wr_tmr = sfr_wr && !sfr_page_p && !s.enable &&
         sfr_hit(sfr_addr, `RTCS_ADDR_TIMER_VALUE);
      wr_ck4 = sfr_wr && sfr_page_p && sfr_hit(sfr_addr, `RTCS_ADDR_CLK_CTL_FOUR);
      wr_pw1 = sfr_wr && sfr_hit(sfr_addr, `RTCS_ADDR_PWR_CTL_ONE);
      wr_system_flag_irq_enable = sfr_wr && !sfr_page_p && sfr_hit(sfr_addr, `RTCS_ADDR_SYS_FLAG_IE);

      next_s.ext_sync = {s.ext_sync[0], external_clock_input};
      next_s.slow_sync = {s.slow_sync[0], internal_slow_oscillator};
      next_s.ext_prev = s.ext_sync[1];
      next_s.slow_prev = s.slow_sync[1];
      next_s.wps_prev = watchdog_prescaler_out;

      // Reserved source codes give no ticks, so the counter stays put.
      case (s.src)
         RTCS_SRC_EXT_PIN: src_tick = s.ext_sync[1] && !s.ext_prev;
         RTCS_SRC_SLOW_OSC: src_tick = s.slow_sync[1] && !s.slow_prev;
         RTCS_SRC_WDT_PSC: src_tick = watchdog_prescaler_out && !s.wps_prev;
         RTCS_SRC_WDT_OVF: src_tick = watchdog_overflow_out;
         RTCS_SRC_SYSCLK: src_tick = 1'b1;
         default: src_tick = 1'b0;
      endcase

      if (s.tap == `RTCS_TAP_DIRECT)
      begin
         tap_tick = src_tick;
      end
      else
      begin
         tap_tick = src_tick && (&(s.psc | ~tap_mask(s.tap)));
      end

      wrap = s.enable && tap_tick && (s.count == `RTCS_COUNT_MAX);

      if (s.enable && src_tick)
      begin
         next_s.psc = 15'(s.psc + `RTCS_PSC_ONE);
      end
      if (s.enable && tap_tick)
      begin
         next_s.count = wrap ? s.reload : 6'(s.count + `RTCS_COUNT_ONE);
      end
      if (wrap)
      begin
         next_s.toggle = !s.toggle;
      end

      if (wr_ctl)
      begin
         next_s.enable = sfr_wdata[`RTCS_BIT_ENABLE];
         next_s.out_en = sfr_wdata[`RTCS_BIT_OUT_EN];
         next_s.reload = sfr_wdata[5:0];
      end
      if (wr_tmr)
      begin
         next_s.tap[1:0] = sfr_wdata[7:6];
         next_s.count = sfr_wdata[5:0];
      end
      if (wr_ck4)
      begin
         next_s.src = sfr_wdata[7:5];
         next_s.psc_ctl = sfr_wdata[4:2];
         next_s.tap[3:2] = sfr_wdata[1:0];
      end
      if (wr_system_flag_irq_enable)
      begin
         next_s.irq_en = sfr_wdata[`RTCS_BIT_IRQ_EN];
      end
      // A wrap in the same cycle as a clearing write keeps the flag set.
      if (wr_pw1 && sfr_wdata[`RTCS_BIT_FLAG])
      begin
         next_s.flag = 1'b0;
      end
      if (wrap)
      begin
         next_s.flag = 1'b1;
      end

      if (sfr_rd)
      begin
         next_s.rdata = `RTCS_READ_ZERO;
         if (sfr_hit(sfr_addr, `RTCS_ADDR_CLK_CONTROL))
         begin
            next_s.rdata = {s.enable, s.out_en, s.reload};
         end
         if (sfr_hit(sfr_addr, `RTCS_ADDR_TIMER_VALUE) && !sfr_page_p && !s.enable)
         begin
            next_s.rdata = {s.tap[1:0], s.count};
         end
         if (sfr_hit(sfr_addr, `RTCS_ADDR_CLK_CTL_FOUR) && sfr_page_p)
         begin
            next_s.rdata = {s.src, s.psc_ctl, s.tap[3:2]};
         end
         if (sfr_hit(sfr_addr, `RTCS_ADDR_PWR_CTL_ONE))
         begin
            next_s.rdata[`RTCS_BIT_FLAG] = s.flag;
         end
         if (sfr_hit(sfr_addr, `RTCS_ADDR_SYS_FLAG_IE) && !sfr_page_p)
         begin
            next_s.rdata[`RTCS_BIT_IRQ_EN] = s.irq_en;
         end
      end
   end

   // No other reset source reaches this block, so warm resets leave it running.
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         s <= RST_STATE;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign sfr_rdata = s.rdata;
   assign overflow_toggle_pin = s.toggle && s.out_en;
   assign overflow_toggle_oe = s.out_en;
   assign overflow_flag = s.flag;
   assign system_flag_irq = s.flag && s.irq_en;
   assign wake_request = s.flag && s.irq_en;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   sequence s_clear_write;
      wr_pw1 && sfr_wdata[`RTCS_BIT_FLAG] && !wrap;
   endsequence

   sequence s_wrap_seen;
      wrap ##1 s.flag;
   endsequence

   property p_reload_on_wrap;
      wrap && !wr_tmr |=> (s.count == $past(s.reload)) && s.flag;
   endproperty
   a_reload_on_wrap: assert property (p_reload_on_wrap)
      else $error("counter did not reload and flag on wrap");

   property p_stopped;
      !s.enable && !wr_tmr |=> $stable(s.count) && $stable(s.psc);
   endproperty
   a_stopped: assert property (p_stopped)
      else $error("counter moved while disabled");

   property p_locked;
      s.enable && sfr_wr && !sfr_page_p && (sfr_addr == `RTCS_ADDR_TIMER_VALUE)
         |=> $stable(s.tap[1:0]);
   endproperty
   a_locked: assert property (p_locked)
      else $error("timer register written while enabled");

   property p_toggle;
      s_wrap_seen |-> (s.toggle != $past(s.toggle, 1));
   endproperty
   a_toggle: assert property (p_toggle)
      else $error("output did not toggle on overflow");

   property p_pin_off;
      !s.out_en |-> !overflow_toggle_pin && !overflow_toggle_oe;
   endproperty
   a_pin_off: assert property (p_pin_off)
      else $error("overflow pin driven while disabled");

   property p_flag_clear;
      s_clear_write |=> !s.flag;
   endproperty
   a_flag_clear: assert property (p_flag_clear)
      else $error("flag not cleared by writing one");

   property p_flag_source;
      !s.flag && !wrap |=> !s.flag;
   endproperty
   a_flag_source: assert property (p_flag_source)
      else $error("flag set without an overflow");

   property p_irq_gate;
      (s.flag && s.irq_en) ##1 (s.flag && !s.irq_en) |-> !system_flag_irq && !wake_request;
   endproperty
   a_irq_gate: assert property (p_irq_gate)
      else $error("interrupt raised while masked");

   property p_direct_step;
      s.enable && (s.src == RTCS_SRC_SYSCLK) && (s.tap == `RTCS_TAP_DIRECT) &&
         (s.count != `RTCS_COUNT_MAX) && !wr_ctl |=> s.count == 6'($past(s.count) + 6'h01);
   endproperty
   a_direct_step: assert property (p_direct_step)
      else $error("undivided tap did not step the counter");

   property p_reserved_src;
      s.enable && (s.src > RTCS_SRC_SYSCLK) |=> $stable(s.psc);
   endproperty
   a_reserved_src: assert property (p_reserved_src)
      else $error("reserved source produced ticks");

   property p_read_locked;
      s.enable && sfr_rd && !sfr_page_p && (sfr_addr == `RTCS_ADDR_TIMER_VALUE)
         |=> sfr_rdata == `RTCS_READ_ZERO;
   endproperty
   a_read_locked: assert property (p_read_locked)
      else $error("timer register read while enabled");

   property p_reload_write;
      wr_ctl |=> s.reload == $past(sfr_wdata[5:0]);
   endproperty
   a_reload_write: assert property (p_reload_write)
      else $error("reload value not taken from a control write");

   property p_tap_high_write;
      wr_ck4 |=> s.tap[3:2] == $past(sfr_wdata[1:0]);
   endproperty
   a_tap_high_write: assert property (p_tap_high_write)
      else $error("tap select not taken from the clock register write");

endmodule : rtcs_timer

// File: rtcs_timer_tb.sv
// Self-checking bench for the real-time clock timer, with a behavioural model in integers.
// Assumes rtcs_map.svh is on the include path; the watchdog overflow input serves as source in the tap tests.
`include "rtcs_map.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk;
   logic reset;
   logic [7:0] sfr_addr;
   logic sfr_page_p;
   logic sfr_wr;
   logic sfr_rd;
   logic [7:0] sfr_wdata;
   logic ext_in;
   logic slow_in;
   logic wps_in;
   logic wov_in;
   wire [7:0] sfr_rdata;
   wire pin;
   wire pin_oe;
   wire flag;
   wire irq;
   wire wake;
   int n_errors;
   int cmp_count;
   int m_count;
   int m_reload;
   int m_psc;
   int m_tap;
   int m_flag;
   int m_tog;
   int m_oe;
   int taps[4] = '{15, 14, 12, 15};
   int srcs[4] = '{0, 1, 2, 4};
   int m_src;
   int m_on;
   logic [2:0] h_ext;
   logic [2:0] h_slow;
   logic h_wps;
   rtcs_timer dut (.clk(clk), .reset(reset), .sfr_addr(sfr_addr), .sfr_page_p(sfr_page_p),
      .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .external_clock_input(ext_in), .internal_slow_oscillator(slow_in),
      .watchdog_prescaler_out(wps_in), .watchdog_overflow_out(wov_in),
      .overflow_toggle_pin(pin), .overflow_toggle_oe(pin_oe), .overflow_flag(flag),
      .system_flag_irq(irq), .wake_request(wake));
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // The external, slow oscillator and watchdog prescaler inputs keep moving so that a wrong source decode shows up as extra ticks.
   always @(posedge clk)
   begin
      ext_in <= 1'($urandom);
      slow_in <= 1'($urandom);
      wps_in <= 1'($urandom);
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic p, input logic [7:0] d);
      @(posedge clk);
      sfr_addr <= a;
      sfr_page_p <= p;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge clk);
      sfr_wr <= 1'b0;
      // Step past the edge so that callers see the register after the write lands.
      #1;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic p, input logic [7:0] exp);
      @(posedge clk);
      sfr_addr <= a;
      sfr_page_p <= p;
      sfr_rd <= 1'b1;
      @(posedge clk);
      sfr_rd <= 1'b0;
      #1 chk(sfr_rdata, exp);
   endtask : rd
   task automatic pins(input int ie);
      chk({7'h00, pin}, 8'(m_tog & m_oe));
      chk({7'h00, pin_oe}, 8'(m_oe));
      chk({7'h00, flag}, 8'(m_flag));
      chk({6'h00, irq, wake}, {6'h00, 1'(m_flag & ie), 1'(m_flag & ie)});
   endtask : pins
   // Each pulse is one high cycle of the watchdog overflow input.
   task automatic pulse(input int n);
      for (int i = 0; i < n; i++)
      begin
         @(posedge clk);
         wov_in <= 1'b1;
         @(posedge clk);
         wov_in <= 1'b0;
      end
   endtask : pulse
   // One edge of the model: a source tick moves the prescaler, a tap tick the counter.
   // Pin sources are seen two edges late through the synchroniser, then edge-detected.
   task automatic model_edge();
      int mask;
      int tick;
      mask = (1 << (15 - m_tap)) - 1;
      case (m_src)
         0: tick = h_ext[1] & !h_ext[2];
         1: tick = h_slow[1] & !h_slow[2];
         2: tick = wps_in & !h_wps;
         3: tick = wov_in;
         4: tick = 1;
         default: tick = 0;
      endcase
      if (tick != 0)
      begin
         if (m_tap == 15 || (m_psc & mask) == mask)
         begin
            if (m_count == 63)
            begin
               m_count = m_reload;
               m_flag = 1;
               m_tog ^= 1;
            end
            else
               m_count++;
         end
         m_psc = (m_psc + 1) & 32'h7FFF;
      end
   endtask : model_edge
   // The model only runs between the enabling and the disabling write.
   always @(posedge clk)
   begin
      h_ext <= {h_ext[1:0], ext_in};
      h_slow <= {h_slow[1:0], slow_in};
      h_wps <= wps_in;
      if (m_on != 0)
         model_edge();
   end
   task automatic defaults();
      m_psc = 0;
      m_tog = 0;
      m_flag = 0;
      m_oe = 0;
      rd(`RTCS_ADDR_CLK_CONTROL, 1'b0, 8'h3F);
      rd(`RTCS_ADDR_TIMER_VALUE, 1'b0, 8'h7F);
      rd(`RTCS_ADDR_CLK_CTL_FOUR, 1'b1, 8'h00);
      rd(`RTCS_ADDR_PWR_CTL_ONE, 1'b0, 8'h00);
      rd(`RTCS_ADDR_SYS_FLAG_IE, 1'b0, 8'h00);
      rd(8'h55, 1'b0, 8'h00);
      pins(0);
      $display("defaults test done");
   endtask : defaults
   task automatic end_of_test();
      $display("compares %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : end_of_test
   initial
   begin
      #2_000_000;
      n_errors++;
      end_of_test();
   end
   initial
   begin
      logic [5:0] c;
      logic [5:0] rl;
      logic oe;
      logic [3:0] t;
      reset = 1'b1;
      sfr_addr = 8'h00;
      sfr_page_p = 1'b0;
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
      sfr_wdata = 8'h00;
      wov_in = 1'b0;
      m_on = 0;
      m_src = 0;
      n_errors = 0;
      cmp_count = 0;
      void'($urandom(32'h7617));
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      defaults();
      foreach (taps[k])
      begin
         t = 4'(taps[k]);
         m_tap = taps[k];
         c = 6'($urandom);
         rl = 6'($urandom);
         oe = 1'($urandom);
         m_src = 3;
         wr(`RTCS_ADDR_CLK_CTL_FOUR, 1'b0, 8'hFF);
         wr(`RTCS_ADDR_CLK_CTL_FOUR, 1'b1, {3'b011, 3'b000, t[3:2]});
         rd(`RTCS_ADDR_CLK_CTL_FOUR, 1'b1, {3'b011, 3'b000, t[3:2]});
         rd(`RTCS_ADDR_CLK_CTL_FOUR, 1'b0, 8'h00);
         wr(`RTCS_ADDR_TIMER_VALUE, 1'b0, {t[1:0], c});
         m_count = c;
         m_reload = rl;
         m_oe = oe;
         wr(`RTCS_ADDR_CLK_CONTROL, 1'b0, {1'b1, oe, rl});
         m_on = 1;
         rd(`RTCS_ADDR_TIMER_VALUE, 1'b0, 8'h00);
         wr(`RTCS_ADDR_TIMER_VALUE, 1'b0, 8'h00);
         pulse(70 + $urandom % 60);
         wr(`RTCS_ADDR_CLK_CONTROL, 1'b0, {1'b0, oe, rl});
         m_on = 0;
         pulse(5);
         rd(`RTCS_ADDR_TIMER_VALUE, 1'b0, {t[1:0], 6'(m_count)});
         rd(`RTCS_ADDR_PWR_CTL_ONE, 1'b0, 8'(m_flag << 4));
         pins(0);
         wr(`RTCS_ADDR_SYS_FLAG_IE, 1'b0, 8'h10);
         rd(`RTCS_ADDR_SYS_FLAG_IE, 1'b0, 8'h10);
         pins(1);
         wr(`RTCS_ADDR_PWR_CTL_ONE, 1'b0, 8'h00);
         pins(1);
         wr(`RTCS_ADDR_PWR_CTL_ONE, 1'b0, 8'h10);
         m_flag = 0;
         pins(1);
         wr(`RTCS_ADDR_SYS_FLAG_IE, 1'b0, 8'h00);
         $display("tap %0d test done", t);
      end
      // The other sources run from the free-running inputs or from the clock itself.
      foreach (srcs[k])
      begin
         m_src = srcs[k];
         m_tap = 15;
         m_oe = 0;
         c = 6'($urandom);
         wr(`RTCS_ADDR_CLK_CTL_FOUR, 1'b1, {3'(m_src), 3'b000, 2'b11});
         wr(`RTCS_ADDR_TIMER_VALUE, 1'b0, {2'b11, c});
         m_count = c;
         wr(`RTCS_ADDR_CLK_CONTROL, 1'b0, {2'b10, rl});
         m_on = 1;
         repeat (100 + $urandom % 100) @(posedge clk);
         wr(`RTCS_ADDR_CLK_CONTROL, 1'b0, {2'b00, rl});
         m_on = 0;
         rd(`RTCS_ADDR_TIMER_VALUE, 1'b0, {2'b11, 6'(m_count)});
         rd(`RTCS_ADDR_PWR_CTL_ONE, 1'b0, 8'(m_flag << 4));
         pins(0);
         $display("source %0d test done", m_src);
      end
      // A reserved source code must leave the counter where it stands.
      m_src = 5;
      wr(`RTCS_ADDR_CLK_CTL_FOUR, 1'b1, 8'hA3);
      wr(`RTCS_ADDR_CLK_CONTROL, 1'b0, {2'b10, 6'(m_reload)});
      m_on = 1;
      pulse(20);
      wr(`RTCS_ADDR_CLK_CONTROL, 1'b0, {2'b00, 6'(m_reload)});
      m_on = 0;
      rd(`RTCS_ADDR_TIMER_VALUE, 1'b0, {2'b11, 6'(m_count)});
      $display("reserved source test done");
      @(posedge clk);
      reset <= 1'b1;
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      defaults();
      end_of_test();
   end
endmodule : tb
